// *** core/sync_serial_channel.sv ***
// one clocked synchronous serial channel with register port, dma hand-off and four requests
`include "sync_serial_regs.svh"

module sync_serial_channel
    import sync_serial_pkg::*;
#(
    parameter int DATA_W = 8
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [2:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic dma_cycle,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic parity_fault_set,
    input wire logic framing_fault_set,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe_n,
    input wire logic rxd_in,
    output logic txd_out,
    output logic txd_oe_n,
    output logic tx_empty_irq,
    output logic rx_full_irq,
    output logic rx_fault_irq,
    output logic tx_done_irq
);

    // ==========================================================
    // registers
    logic [7:0] serial_format_reg;
    logic [7:0] baud_divisor_reg;
    logic [7:0] serial_control_reg;
    logic [DATA_W-1:0] tx_holding_reg;
    logic [DATA_W-1:0] rx_holding_reg;
    logic [DATA_W-1:0] tx_shift_reg;
    logic [DATA_W-1:0] rx_shift_reg;
    logic tx_empty_flag;
    logic rx_full_flag;
    logic rx_overrun_flag;
    logic rx_framing_fault;
    logic rx_parity_fault;
    logic tx_done_flag;
    tx_state_t tx_state;
    logic [2:0] tx_cnt;
    logic [2:0] rx_cnt;
    logic [2:0] eng_cnt;
    logic [7:0] half_cnt;
    logic eng_active;
    logic sck_level;
    logic sck_s1, sck_s2, sck_s3;
    logic rxd_s1, rxd_s2;

    // ==========================================================
    // decode
    logic wr_format, wr_baud, wr_ctl, wr_txh, wr_flags, rd_rxh;
    logic sync_mode, int_clk, tx_en, rx_en, rx_ie;
    logic err_any, pf_block, tx_going, rx_run, eng_want;
    logic fall, rise, tx_disable;
    logic rx_last, tx_last_fall;

    assign wr_format = reg_wr && reg_addr == `OFS_FORMAT;
    assign wr_baud = reg_wr && reg_addr == `OFS_BAUD;
    assign wr_ctl = reg_wr && reg_addr == `OFS_CONTROL;
    assign wr_txh = reg_wr && reg_addr == `OFS_TX_HOLD;
    assign wr_flags = reg_wr && reg_addr == `OFS_FLAGS;
    assign rd_rxh = reg_rd && reg_addr == `OFS_RX_HOLD;
    assign sync_mode = serial_format_reg[`FMT_SYNC_MODE];
    // async framing lives outside; in that mode this channel stays idle
    assign int_clk = sync_mode && !serial_control_reg[`CTL_CLK_SEL_HI];
    assign tx_en = serial_control_reg[`CTL_TX_ENABLE];
    assign rx_en = serial_control_reg[`CTL_RX_ENABLE];
    assign rx_ie = serial_control_reg[`CTL_RX_IRQ_EN];
    assign err_any = rx_overrun_flag || rx_framing_fault || rx_parity_fault;
    assign pf_block = rx_framing_fault || rx_parity_fault;
    // any receive error holds back the receiver and a new transmit start
    assign rx_run = sync_mode && rx_en && !err_any;
    assign tx_disable = wr_ctl && tx_en && !reg_wdata[`CTL_TX_ENABLE];
    assign tx_going = tx_state == TX_SHIFT;
    // receive-only keeps the internal clock running; with transmit on it follows data
    assign eng_want = tx_going || (rx_run && !tx_en);

    // ==========================================================
    // input synchronisers
    // the third clock stage only keeps the previous level for edge finding
    always_ff @(posedge sys_clk) begin
        sck_s1 <= sck_in;
        sck_s2 <= sck_s1;
        sck_s3 <= sck_s2;
        rxd_s1 <= rxd_in;
        rxd_s2 <= rxd_s1;
    end

    // ==========================================================
    // serial clock: internal divider or external pin edges
    logic int_fall, int_rise;
    assign int_fall = eng_active && half_cnt == 8'h00 && sck_level;
    assign int_rise = eng_active && half_cnt == 8'h00 && !sck_level;
    assign fall = int_clk ? int_fall : (sync_mode && sck_s3 && !sck_s2);
    assign rise = int_clk ? int_rise : (sync_mode && !sck_s3 && sck_s2);

    // level that the divider takes at this edge; the pin copies it so that
    // data and clock move in the same cycle and nothing changes at a rise
    logic next_sck_level;
    always_comb begin
        next_sck_level = sck_level;
        if (!int_clk || !eng_active) begin
            next_sck_level = 1'b1;
        end else if (half_cnt == 8'h00) begin
            next_sck_level = !sck_level;
        end
    end

    // half period is baud divisor plus one system clock
    // limitation: receiving on the internal clock needs a divisor of 2 or more,
    // since the line synchroniser costs two clocks before a rise can sample it
    always_ff @(posedge sys_clk) begin
        if (srst || !int_clk) begin
            eng_active <= 1'b0;
            sck_level <= 1'b1;
            half_cnt <= 8'h00;
            eng_cnt <= 3'h0;
        end else if (!eng_active) begin
            sck_level <= 1'b1;
            eng_cnt <= 3'h0;
            half_cnt <= baud_divisor_reg;
            if (eng_want) begin
                eng_active <= 1'b1;
            end
        end else if (half_cnt != 8'h00) begin
            half_cnt <= half_cnt - 8'h01;
        end else begin
            half_cnt <= baud_divisor_reg;
            sck_level <= !sck_level;
            if (!sck_level) begin
                eng_cnt <= eng_cnt + 3'h1;
                // stop only on the eighth rising edge so the pin rests high
                if (eng_cnt == `LAST_BIT && !eng_want) begin
                    eng_active <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // software registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            serial_format_reg <= `RST_FORMAT;
            baud_divisor_reg <= `RST_BAUD;
            serial_control_reg <= `RST_CONTROL;
            tx_holding_reg <= '0;
        end else begin
            if (wr_format) begin
                serial_format_reg <= reg_wdata;
            end
            if (wr_baud) begin
                baud_divisor_reg <= reg_wdata;
            end
            if (wr_ctl) begin
                serial_control_reg <= reg_wdata;
            end
            if (wr_txh) begin
                tx_holding_reg <= reg_wdata;
            end
        end
    end

    // ==========================================================
    // transmitter
    assign tx_last_fall = fall && tx_going && tx_cnt == `LAST_BIT;

    always_ff @(posedge sys_clk) begin
        if (srst || !tx_en || !sync_mode) begin
            tx_state <= TX_IDLE;
            tx_shift_reg <= '0;
            tx_cnt <= 3'h0;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    if (!tx_empty_flag && !err_any) begin
                        tx_shift_reg <= tx_holding_reg;
                        tx_cnt <= 3'h0;
                        tx_state <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    if (fall) begin
                        tx_shift_reg <= tx_shift_reg >> 1;
                        tx_cnt <= tx_cnt + 3'h1;
                        if (tx_cnt == `LAST_BIT) begin
                            if (!tx_empty_flag && !pf_block) begin
                                tx_shift_reg <= tx_holding_reg;
                            end else begin
                                tx_state <= TX_STOP;
                            end
                        end
                    end
                end
                TX_STOP: begin
                    if (rise) begin
                        tx_state <= TX_IDLE;
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    // line holds its last bit between frames
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            txd_out <= 1'b1;
        end else if (fall && tx_going) begin
            txd_out <= tx_shift_reg[0];
        end
    end

    // empty flag: set on load, cleared by software or dma write
    logic tx_load;
    assign tx_load = (tx_state == TX_IDLE && tx_en && sync_mode && !tx_empty_flag && !err_any)
        || (tx_last_fall && !tx_empty_flag && !pf_block);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tx_empty_flag <= 1'b1;
        end else if (tx_load || tx_disable) begin
            tx_empty_flag <= 1'b1;
        end else if (wr_txh && dma_cycle) begin
            tx_empty_flag <= 1'b0;
        end else if (wr_flags && !reg_wdata[`FLG_TX_EMPTY]) begin
            tx_empty_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tx_done_flag <= 1'b1;
        end else if (tx_last_fall && (tx_empty_flag || pf_block)) begin
            tx_done_flag <= 1'b1;
        end else if (tx_load) begin
            tx_done_flag <= 1'b0;
        end else if (wr_flags && !reg_wdata[`FLG_TX_DONE]) begin
            tx_done_flag <= 1'b0;
        end
    end

    // ==========================================================
    // receiver
    assign rx_last = rise && rx_run && rx_cnt == `LAST_BIT;

    // leaving receive enable only stops shifting; flags and holding stay put
    always_ff @(posedge sys_clk) begin
        if (srst || !rx_run) begin
            rx_cnt <= 3'h0;
            rx_shift_reg <= '0;
        end else if (rise) begin
            rx_shift_reg <= {rxd_s2, rx_shift_reg[DATA_W-1:1]};
            rx_cnt <= rx_cnt + 3'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rx_holding_reg <= '0;
        end else if (rx_last && !rx_full_flag) begin
            rx_holding_reg <= {rxd_s2, rx_shift_reg[DATA_W-1:1]};
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rx_full_flag <= 1'b0;
        end else if (rx_last && !rx_full_flag) begin
            rx_full_flag <= 1'b1;
        end else if (rd_rxh && dma_cycle) begin
            rx_full_flag <= 1'b0;
        end else if (wr_flags && !reg_wdata[`FLG_RX_FULL]) begin
            rx_full_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rx_overrun_flag <= 1'b0;
        end else if (rx_last && rx_full_flag) begin
            rx_overrun_flag <= 1'b1;
        end else if (wr_flags && !reg_wdata[`FLG_OVERRUN]) begin
            rx_overrun_flag <= 1'b0;
        end
    end

    // parity and framing faults come from the asynchronous receiver outside
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rx_framing_fault <= 1'b0;
            rx_parity_fault <= 1'b0;
        end else begin
            if (framing_fault_set) begin
                rx_framing_fault <= 1'b1;
            end else if (wr_flags && !reg_wdata[`FLG_FRAMING]) begin
                rx_framing_fault <= 1'b0;
            end
            if (parity_fault_set) begin
                rx_parity_fault <= 1'b1;
            end else if (wr_flags && !reg_wdata[`FLG_PARITY]) begin
                rx_parity_fault <= 1'b0;
            end
        end
    end

    // ==========================================================
    // read port, data one cycle after the strobe
    logic [DATA_W-1:0] next_rdata;
    always_comb begin
        next_rdata = '0;
        case (reg_addr)
            `OFS_FORMAT: next_rdata = serial_format_reg;
            `OFS_BAUD: next_rdata = baud_divisor_reg;
            `OFS_CONTROL: next_rdata = serial_control_reg;
            `OFS_TX_HOLD: next_rdata = tx_holding_reg;
            `OFS_FLAGS: next_rdata = {tx_empty_flag, rx_full_flag, rx_overrun_flag,
                rx_framing_fault, rx_parity_fault, tx_done_flag, 2'b00};
            `OFS_RX_HOLD: next_rdata = rx_holding_reg;
            default: next_rdata = '0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= '0;
        end
    end

    // ==========================================================
    // pins
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sck_out <= 1'b1;
            sck_oe_n <= 1'b1;
            txd_oe_n <= 1'b1;
        end else begin
            sck_out <= next_sck_level;
            sck_oe_n <= !int_clk;
            txd_oe_n <= !(tx_en && sync_mode);
        end
    end

    // ==========================================================
    // requests: separate levels, the interrupt controller ranks them
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tx_empty_irq <= 1'b0;
            rx_full_irq <= 1'b0;
            rx_fault_irq <= 1'b0;
            tx_done_irq <= 1'b0;
        end else begin
            tx_empty_irq <= tx_empty_flag && serial_control_reg[`CTL_TX_EMPTY_IRQ_EN];
            rx_full_irq <= rx_full_flag && rx_ie;
            rx_fault_irq <= err_any && rx_ie;
            tx_done_irq <= tx_done_flag && serial_control_reg[`CTL_TX_DONE_IRQ_EN];
        end
    end

endmodule

// *** inc/sync_serial_regs.svh ***
// register map, field positions, reset values and timing counts of the serial channel
// What this block does
// - transmit and receive share one serial clock, each double buffered; on the internal clock with transmit on, receive is clocked only while transmitting.
// - each bit is driven from one falling clock edge to the next, valid at rising.
// - bits go out least significant first; line holds the last bit afterwards.
// - every character is exactly eight data bits, no parity or extra bit.
// - clock source is internal divider or external pin, chosen by mode and the high select bit.
// - internal clock gives eight pulses per character; clock pin idles high.
// - empty flag found clear: copy holding into shifter, set empty flag, start shifting.
// - loading the shifter with empty interrupt enabled raises the empty request.
// - at bit 7 empty flag clear chains next frame, else set done flag.
// - clearing transmit enable sets the empty flag and resets the shifter.
// - clearing receive enable keeps full flag, error flags and holding register.
// - receiver shifts in lsb first; after eight bits loads holding if not full.
// - while an error flag is set no reception sets the full flag.
// - parity or framing flag set blocks both transmission and reception.
// - full flag set with receive interrupt enabled requests the full interrupt.
// - any error flag with receive interrupt enabled requests the fault interrupt, never dma.
// - empty request may start dma; a dma write of holding clears the empty flag.
// - full request may start dma; a dma read of holding clears the full flag.
// - done flag with its enable requests the done interrupt, never dma.
// - four separate request lines; priority fault, full, empty, done.
// - character completing while full sets overrun and is not copied.
`ifndef SYNC_SERIAL_REGS_SVH
`define SYNC_SERIAL_REGS_SVH

// ==========================================================
// offsets
`define OFS_FORMAT 3'h0
`define OFS_BAUD 3'h1
`define OFS_CONTROL 3'h2
`define OFS_TX_HOLD 3'h3
`define OFS_FLAGS 3'h4
`define OFS_RX_HOLD 3'h5

// ==========================================================
// format register fields
`define FMT_SYNC_MODE 7
// control register fields
`define CTL_TX_EMPTY_IRQ_EN 7
`define CTL_RX_IRQ_EN 6
`define CTL_TX_ENABLE 5
`define CTL_RX_ENABLE 4
`define CTL_MULTIPROC_WAIT_EN 3
`define CTL_TX_DONE_IRQ_EN 2
`define CTL_CLK_SEL_HI 1
`define CTL_CLK_SEL_LO 0
// flag register fields
`define FLG_TX_EMPTY 7
`define FLG_RX_FULL 6
`define FLG_OVERRUN 5
`define FLG_FRAMING 4
`define FLG_PARITY 3
`define FLG_TX_DONE 2

// ==========================================================
// reset values and counts
`define RST_FORMAT 8'h00
`define RST_BAUD 8'hff
`define RST_CONTROL 8'h00
`define LAST_BIT 3'h7

`endif

// *** inc/sync_serial_pkg.sv ***
// types shared by the serial channel
package sync_serial_pkg;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SHIFT = 2'b01,
        TX_STOP = 2'b10
    } tx_state_t;
endpackage

// *** tb/sync_serial_chk_props.sv ***
// port checker of the serial channel
`include "sync_serial_regs.svh"

// ==========================================================
// checker
module sync_serial_chk #(
    parameter int DATA_W = 8
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [2:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic dma_cycle,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic parity_fault_set,
    input wire logic framing_fault_set,
    input wire logic sck_in,
    input wire logic sck_out,
    input wire logic sck_oe_n,
    input wire logic rxd_in,
    input wire logic txd_out,
    input wire logic txd_oe_n,
    input wire logic tx_empty_irq,
    input wire logic rx_full_irq,
    input wire logic rx_fault_irq,
    input wire logic tx_done_irq
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    wire logic wctl = reg_wr && reg_addr == `OFS_CONTROL;
    wire logic wrx = wctl || (reg_wr && reg_addr == `OFS_FLAGS);
    a_reset_idle:
    assert property ($fell(srst) |-> sck_out && txd_out && sck_oe_n && txd_oe_n
        && !tx_empty_irq && !rx_full_irq) else $error("bad idle levels after reset");
    a_rdata_quiet:
    assert property (!$past(reg_rd) |-> reg_rdata == '0) else $error("read data not quiet");
    // a bit may only move just after a falling clock edge
    a_txd_at_fall:
    assert property (!sck_oe_n && !txd_oe_n && $past(!txd_oe_n) && $changed(txd_out)
        |-> $fell(sck_out)) else $error("data moved off a fall");
    a_stable_rise:
    assert property (!sck_oe_n && !txd_oe_n && $rose(sck_out) |-> $stable(txd_out))
        else $error("data moved at a rise");
    a_fault_holds:
    assert property (rx_fault_irq && !wrx && !$past(wrx) |=> rx_fault_irq)
        else $error("fault request dropped by itself");
    a_empty_gate:
    assert property (wctl && !reg_wdata[`CTL_TX_EMPTY_IRQ_EN] |-> ##2 !tx_empty_irq)
        else $error("empty request while disabled");
    a_full_gate:
    assert property (wctl && !reg_wdata[`CTL_RX_IRQ_EN] |-> ##2 !rx_full_irq && !rx_fault_irq)
        else $error("receive request while disabled");
    a_done_gate:
    assert property (wctl && !reg_wdata[`CTL_TX_DONE_IRQ_EN] |-> ##2 !tx_done_irq)
        else $error("done request while disabled");
    a_dma_clear:
    assert property (reg_rd && dma_cycle && reg_addr == `OFS_RX_HOLD |-> ##2 !rx_full_irq)
        else $error("dma read left full request");
    c_done: cover property ($rose(tx_done_irq));
    c_fault: cover property ($rose(rx_fault_irq));
    c_dma: cover property (reg_rd && dma_cycle);
endmodule

bind sync_serial_channel sync_serial_chk #(.DATA_W(DATA_W)) u_sync_serial_chk (.sys_clk, .srst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .dma_cycle, .reg_rdata, .parity_fault_set,
    .framing_fault_set, .sck_in, .sck_out, .sck_oe_n, .rxd_in, .txd_out, .txd_oe_n,
    .tx_empty_irq, .rx_full_irq, .rx_fault_irq, .tx_done_irq);

// *** tb/sync_peer.sv ***
// clocked serial peer: shifts a word out on falls, captures the line on rises
module sync_peer (
    input wire logic sck,
    input wire logic txd,
    input wire logic restart,
    input wire logic ext_go,
    input wire logic [15:0] word,
    output logic rxd,
    output logic ext_sck,
    output logic [15:0] cap,
    output int nr
);
    timeunit 1ns;
    timeprecision 100ps;
    int nf = 0;
    initial begin
        rxd = 1'b1;
        cap = 16'h0000;
        nr = 0;
    end
    // ==========================================================
    // clock of its own, only inside a frame, resting high; odd phase on purpose
    initial begin
        ext_sck = 1'b1;
        #1.3;
        forever #24 if (!ext_sck || (ext_go && nr < 8)) ext_sck = ~ext_sck;
    end
    always @(posedge restart) begin
        nf = 0;
        nr = 0;
    end
    always @(negedge sck) begin
        rxd = word[nf[3:0]];
        nf++;
    end
    // a released line flips so that a stale bit can never pass
    always @(posedge sck) begin
        cap = {txd, cap[15:1]};
        nr++;
        if (nr % 8 == 0)
            fork
                #20 if (nf == nr) rxd = ~rxd;
            join_none
    end
endmodule

// *** tb/tb_sync_serial_channel.sv ***
// bench of the serial channel against the clocked peer
`include "sync_serial_regs.svh"
module tb_sync_serial_channel;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0, reg_rd = 1'b0, dma_cycle = 1'b0, par_set = 1'b0, frm_set = 1'b0;
    logic restart = 1'b0, ext_go = 1'b0;
    logic [7:0] reg_rdata, rdata, t1, t2, p1, p2;
    logic sck_out, sck_oe_n, txd_out, txd_oe_n, rxd, ext_sck;
    logic tx_empty_irq, rx_full_irq, rx_fault_irq, tx_done_irq;
    logic [15:0] word = 16'h0000, cap;
    int nr, bad_count = 0, total_checks = 0;
    logic [2:0] ra [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6};
    logic [7:0] rv [5] = '{`RST_FORMAT, `RST_BAUD, `RST_CONTROL, 8'h84, 8'h00};
    wire logic sck_pin = sck_oe_n ? ext_sck : sck_out;
    wire logic txd_pin = txd_oe_n ? 1'b1 : txd_out;
    always #2 sys_clk = ~sys_clk;
    sync_serial_channel u_sync_serial_channel (.sys_clk, .srst, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .dma_cycle, .reg_rdata, .parity_fault_set(par_set),
        .framing_fault_set(frm_set), .sck_in(sck_pin), .sck_out, .sck_oe_n, .rxd_in(rxd),
        .txd_out, .txd_oe_n, .tx_empty_irq, .rx_full_irq, .rx_fault_irq, .tx_done_irq);
    sync_peer u_sync_peer (.sck(sck_pin), .txd(txd_pin), .restart, .ext_go, .word, .rxd,
        .ext_sck, .cap, .nr);
    // ==========================================================
    // helpers
    function automatic logic [7:0] fl(input logic e, f, o, r, p, d);
        return {e, f, o, r, p, d, 2'b00};
    endfunction
    task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic m = 1'b0);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        dma_cycle <= m;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        dma_cycle <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic m = 1'b0);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        dma_cycle <= m;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        dma_cycle <= 1'b0;
        #1 rdata = reg_rdata;
    endtask
    task automatic chk(input string n, input logic [15:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic pulse(input logic framing);
        @(posedge sys_clk);
        par_set <= !framing;
        frm_set <= framing;
        @(posedge sys_clk);
        par_set <= 1'b0;
        frm_set <= 1'b0;
    endtask
    // one byte, or two chained when n is 16; the second comes by dma
    task automatic send(input logic [7:0] a, b, input int n);
        restart <= 1'b1;
        wr(`OFS_TX_HOLD, a);
        restart <= 1'b0;
        wr(`OFS_FLAGS, 8'h7f);
        repeat (4) @(posedge sys_clk);
        ext_go <= 1'b1;
        if (n > 8)
            wr(`OFS_TX_HOLD, b, 1'b1);
        repeat (3000) if (nr < n) @(posedge sys_clk);
        repeat (16) @(posedge sys_clk);
        ext_go <= 1'b0;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #100000;
        bad_count++;
        tally_and_finish;
    end
    // ==========================================================
    // tests
    initial begin
        t1 = 8'($urandom(32'hf0f3fb47));
        repeat (20) @(posedge sys_clk);
        srst <= 1'b0;
        foreach (ra[i]) begin
            rd(ra[i]);
            chk("reset value", rdata, rv[i]);
        end
        wr(`OFS_FORMAT, 8'h80);
        wr(`OFS_BAUD, 8'h05);
        wr(`OFS_CONTROL, 8'h00);
        repeat (16) @(posedge sys_clk);
        wr(`OFS_CONTROL, 8'hf4);
        for (int i = 0; i < 3; i++) begin
            t1 = i ? 8'($urandom) : 8'h80;
            p1 = i ? 8'($urandom) : 8'h01;
            word <= {8'h00, p1};
            send(t1, 8'h00, 8);
            chk("tx byte", cap[15:8], t1);
            chk("rises", 16'(nr), 16'd8);
            chk("line hold", txd_out, t1[7]);
            chk("clock idle", sck_pin, 1'b1);
            chk("pins driven", {sck_oe_n, txd_oe_n}, 2'b00);
            chk("irqs", {tx_empty_irq, rx_full_irq, rx_fault_irq, tx_done_irq}, 4'hd);
            rd(`OFS_FLAGS);
            chk("flags", rdata, fl(1, 1, 0, 0, 0, 1));
            rd(`OFS_RX_HOLD, 1'b1);
            chk("rx byte", rdata, p1);
            repeat (2) @(posedge sys_clk);
            chk("full irq", rx_full_irq, 1'b0);
        end
        t1 = 8'($urandom);
        t2 = 8'($urandom);
        p1 = 8'($urandom);
        p2 = 8'($urandom);
        word <= {p2, p1};
        send(t1, t2, 16);
        chk("chained", cap, {t2, t1});
        chk("rises", 16'(nr), 16'd16);
        rd(`OFS_FLAGS);
        chk("overrun", rdata, fl(1, 1, 1, 0, 0, 1));
        chk("fault irq", rx_fault_irq, 1'b1);
        rd(`OFS_RX_HOLD, 1'b1);
        chk("kept byte", rdata, p1);
        repeat (40) @(posedge sys_clk);
        rd(`OFS_FLAGS);
        chk("no refill", rdata, fl(1, 0, 1, 0, 0, 1));
        wr(`OFS_CONTROL, 8'he4);
        rd(`OFS_FLAGS);
        chk("rx off flags", rdata, fl(1, 0, 1, 0, 0, 1));
        rd(`OFS_RX_HOLD);
        chk("rx off hold", rdata, p1);
        wr(`OFS_FLAGS, 8'hdf);
        wr(`OFS_CONTROL, 8'hf4);
        pulse(1'b0);
        send(8'h5a, 8'h00, 8);
        chk("blocked", 16'(nr), 16'd0);
        rd(`OFS_FLAGS);
        chk("parity", rdata, fl(0, 0, 0, 0, 1, 1));
        chk("fault irq", rx_fault_irq, 1'b1);
        wr(`OFS_CONTROL, 8'hd4);
        pulse(1'b1);
        rd(`OFS_FLAGS);
        chk("tx off", rdata, fl(1, 0, 0, 1, 1, 1));
        chk("tx released", txd_oe_n, 1'b1);
        wr(`OFS_FLAGS, 8'he7);
        repeat (2) @(posedge sys_clk);
        chk("fault gone", rx_fault_irq, 1'b0);
        wr(`OFS_CONTROL, 8'h02);
        repeat (16) @(posedge sys_clk);
        wr(`OFS_CONTROL, 8'hf6);
        t1 = 8'($urandom);
        p1 = 8'($urandom);
        word <= {8'h00, p1};
        send(t1, 8'h00, 8);
        chk("ext tx", cap[15:8], t1);
        chk("pin free", sck_oe_n, 1'b1);
        rd(`OFS_RX_HOLD, 1'b1);
        chk("ext rx", rdata, p1);
        tally_and_finish;
    end
endmodule
